//--- verilog/mwu_defines.svh
`ifndef MWU_DEFINES_SVH
`define MWU_DEFINES_SVH

// ********************
// Message framing
// ********************
`define MWU_ID_REQ 8'h12
`define MWU_ID_RSP 8'h13
`define MWU_ID_ERR 8'h93
`define MWU_LEN_REQ 16'h0017
`define MWU_LEN_NORD 16'h0004
`define MWU_LEN_RD 16'h0007
`define MWU_LEN_ERR 16'h0003

// ********************
// Mode byte
// ********************
`define MWU_MODE_SUPP 7
`define MWU_MODE_NOWR 6
`define MWU_MODE_NORD 5
`define MWU_W8 3'h1
`define MWU_W16 3'h2
`define MWU_W64 3'h4
`define MWU_LANE_W8 64'h0000_0000_0000_00FF
`define MWU_LANE_W16 64'h0000_0000_0000_FFFF
`define MWU_LANE_W64 64'hFFFF_FFFF_FFFF_FFFF

// ********************
// Return codes
// ********************
`define MWU_RC_OK 8'h00
`define MWU_RC_UNSUP 8'h01
`define MWU_RC_LEN 8'h02
`define MWU_RC_TID 8'h03
`define MWU_RC_MODE 8'h04
`define MWU_RC_ADDR 8'h0A
`define MWU_RC_FAIL 8'h0C
`define MWU_RC_DEV 8'hFF

// ********************
// Controller registers
// ********************
`define MWU_REG_CTRL 8'h00
`define MWU_REG_TID 8'h04
`define MWU_REG_MODE 8'h08
`define MWU_REG_ADDR 8'h0C
`define MWU_REG_KEEP_LO 8'h10
`define MWU_REG_KEEP_HI 8'h14
`define MWU_REG_SET_LO 8'h18
`define MWU_REG_SET_HI 8'h1C
`define MWU_REG_RSP_INFO 8'h20
`define MWU_REG_RSP_DATA 8'h24
`define MWU_REG_STAT 8'h28
`define MWU_REG_MASK 8'h2C
`define MWU_REG_RSP_ECHO 8'h30
`define MWU_STAT_SENT 0
`define MWU_STAT_NORM 1
`define MWU_STAT_ERR 2
`define MWU_RST_MODE 8'h01

`endif

//--- verilog/mwu_pkg.sv
package mwu_pkg;

  typedef enum logic [2:0] {
    MWU_IDLE = 3'b000,
    MWU_CHK = 3'b001,
    MWU_RDCUR = 3'b010,
    MWU_MERGE = 3'b011,
    MWU_WRITE = 3'b100,
    MWU_RDBK = 3'b101,
    MWU_CAPT = 3'b110,
    MWU_RESP = 3'b111
  } mwu_dev_state_t;

  typedef struct packed {
    mwu_dev_state_t st;
    logic [15:0] tid;
    logic [7:0] mode;
    logic [31:0] addr;
    logic [63:0] keep;
    logic [63:0] set;
    logic [7:0] code;
    logic [63:0] wdata;
    logic reg_wr;
    logic reg_rd;
    logic rsp_valid;
    logic [7:0] rsp_id;
    logic [15:0] rsp_len;
    logic [7:0] rsp_code;
    logic [31:0] rsp_data;
  } mwu_dev_st_t;

  typedef struct packed {
    logic busy;
    logic [15:0] tid;
    logic [7:0] mode;
    logic [31:0] addr;
    logic [63:0] keep;
    logic [63:0] set;
    logic [7:0] rsp_id;
    logic [15:0] rsp_len;
    logic [7:0] rsp_code;
    logic [31:0] rsp_data;
    logic [15:0] rsp_tid;
    logic [7:0] rsp_mode;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] rdata;
  } mwu_mst_st_t;

endpackage : mwu_pkg

//--- verilog/mwu_link.sv
`timescale 1ns/1ps
interface mwu_link;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_msg_id;
  logic [15:0] req_len;
  logic [15:0] req_tid;
  logic [7:0] req_mode;
  logic [31:0] req_addr;
  logic [63:0] req_keep;
  logic [63:0] req_set;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_msg_id;
  logic [15:0] rsp_len;
  logic [15:0] rsp_tid;
  logic [7:0] rsp_mode;
  logic [7:0] rsp_code;
  logic [31:0] rsp_data;

  modport dev (
    input req_valid, req_msg_id, req_len, req_tid, req_mode, req_addr, req_keep, req_set,
    input rsp_ready,
    output req_ready,
    output rsp_valid, rsp_msg_id, rsp_len, rsp_tid, rsp_mode, rsp_code, rsp_data
  );

  modport mst (
    output req_valid, req_msg_id, req_len, req_tid, req_mode, req_addr, req_keep, req_set,
    output rsp_ready,
    input req_ready,
    input rsp_valid, rsp_msg_id, rsp_len, rsp_tid, rsp_mode, rsp_code, rsp_data
  );
endinterface : mwu_link

//--- verilog/mwu_merge.sv
`timescale 1ns/1ps
`include "mwu_defines.svh"
module mwu_merge (
  input wire logic [63:0] cur,
  input wire logic [63:0] keep,
  input wire logic [63:0] set,
  input wire logic [2:0] wcode,
  output logic [63:0] result,
  output logic [63:0] lane_mask,
  output logic [7:0] be
);
  always_comb begin
    unique case (wcode)
      `MWU_W8: lane_mask = `MWU_LANE_W8;
      `MWU_W16: lane_mask = `MWU_LANE_W16;
      `MWU_W64: lane_mask = `MWU_LANE_W64;
      // Reserved widths never reach a write
      default: lane_mask = '0;
    endcase
  end

  assign result = (cur & ~lane_mask) | (((cur & keep) | (set & ~keep)) & lane_mask);

  for (genvar i = 0; i < 8; i++) begin : g_be
    assign be[i] = lane_mask[8*i];
  end
endmodule : mwu_merge

//--- verilog/mwu_dev_end.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "mwu_defines.svh"
module mwu_dev_end (
  input wire logic mclk,
  input wire logic rst_b,
  mwu_link.dev lnk,
  output logic [31:0] reg_addr,
  output logic [7:0] reg_be,
  output logic [63:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_addr_bad,
  input wire logic reg_fail
);

  // ********************
  // State
  // ********************
  mwu_pkg::mwu_dev_st_t s_q;
  mwu_pkg::mwu_dev_st_t s_d;
  logic [63:0] merged;
  logic [63:0] lane_mask;
  logic [7:0] be;
  logic [7:0] code;
  logic mode_bad;
  logic width_ok;

  mwu_merge u_merge (
    .cur(reg_rdata),
    .keep(s_q.keep),
    .set(s_q.set),
    .wcode(s_q.mode[2:0]),
    .result(merged),
    .lane_mask(lane_mask),
    .be(be)
  );

  // ********************
  // Request checks
  // ********************
  // Legal width codes
  assign width_ok = (lnk.req_mode[2:0] == `MWU_W8) ||
                    (lnk.req_mode[2:0] == `MWU_W16) ||
                    (lnk.req_mode[2:0] == `MWU_W64);

  assign mode_bad = lnk.req_mode[`MWU_MODE_NOWR] | ~width_ok;

  // ********************
  // Link outputs
  // ********************
  // Only one message in flight; the master waits for ready
  assign lnk.req_ready = (s_q.st == mwu_pkg::MWU_IDLE);
  assign lnk.rsp_valid = s_q.rsp_valid;
  assign lnk.rsp_msg_id = s_q.rsp_id;
  assign lnk.rsp_len = s_q.rsp_len;
  assign lnk.rsp_tid = s_q.tid;
  assign lnk.rsp_mode = s_q.mode;
  assign lnk.rsp_code = s_q.rsp_code;
  assign lnk.rsp_data = s_q.rsp_data;

  // ********************
  // Register port
  // ********************
  assign reg_addr = s_q.addr;
  assign reg_be = be;
  assign reg_wdata = s_q.wdata;
  assign reg_wr = s_q.reg_wr;
  assign reg_rd = s_q.reg_rd;

  // ********************
  // Sequencer
  // ********************
  always_comb begin
    code = s_q.code;
    s_d = s_q;
    s_d.reg_wr = 1'b0;
    s_d.reg_rd = 1'b0;
    unique case (s_q.st)
      mwu_pkg::MWU_IDLE: begin
        if (lnk.req_valid) begin
          s_d.tid = lnk.req_tid;
          s_d.mode = lnk.req_mode;
          s_d.addr = lnk.req_addr;
          s_d.keep = lnk.req_keep;
          s_d.set = lnk.req_set;
          if (lnk.req_msg_id != `MWU_ID_REQ) begin
            s_d.code = `MWU_RC_UNSUP;
          end else if (lnk.req_len != `MWU_LEN_REQ) begin
            s_d.code = `MWU_RC_LEN;
          end else if (mode_bad) begin
            s_d.code = `MWU_RC_MODE;
          end else begin
            s_d.code = `MWU_RC_OK;
          end
          s_d.st = mwu_pkg::MWU_CHK;
        end
      end
      mwu_pkg::MWU_CHK: begin
        if (code == `MWU_RC_OK && reg_addr_bad) begin
          code = `MWU_RC_ADDR;
        end else if (code == `MWU_RC_OK && reg_fail) begin
          code = `MWU_RC_DEV;
        end
        s_d.code = code;
        if (code != `MWU_RC_OK) begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_id = `MWU_ID_ERR;
          s_d.rsp_len = `MWU_LEN_ERR;
          s_d.rsp_code = code;
          s_d.rsp_data = '0;
          s_d.st = mwu_pkg::MWU_RESP;
        end else begin
          // Fetch current contents for the merge
          s_d.reg_rd = 1'b1;
          s_d.st = mwu_pkg::MWU_RDCUR;
        end
      end
      mwu_pkg::MWU_RDCUR: begin
        s_d.st = mwu_pkg::MWU_MERGE;
      end
      mwu_pkg::MWU_MERGE: begin
        s_d.wdata = merged;
        s_d.reg_wr = 1'b1;
        s_d.st = mwu_pkg::MWU_WRITE;
      end
      mwu_pkg::MWU_WRITE: begin
        if (!s_q.mode[`MWU_MODE_NORD]) begin
          s_d.reg_rd = 1'b1;
          s_d.st = mwu_pkg::MWU_RDBK;
        end else if (s_q.mode[`MWU_MODE_SUPP]) begin
          s_d.st = mwu_pkg::MWU_IDLE;
        end else begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_id = `MWU_ID_RSP;
          s_d.rsp_len = `MWU_LEN_NORD;
          s_d.rsp_code = `MWU_RC_OK;
          s_d.rsp_data = '0;
          s_d.st = mwu_pkg::MWU_RESP;
        end
      end
      mwu_pkg::MWU_RDBK: begin
        s_d.st = mwu_pkg::MWU_CAPT;
      end
      mwu_pkg::MWU_CAPT: begin
        s_d.rsp_valid = 1'b1;
        s_d.rsp_id = `MWU_ID_RSP;
        s_d.rsp_len = `MWU_LEN_RD;
        s_d.rsp_code = `MWU_RC_OK;
        // Four data bytes only: upper half of a 64-bit word is not returned
        s_d.rsp_data = reg_rdata[31:0] & lane_mask[31:0];
        s_d.st = mwu_pkg::MWU_RESP;
      end
      mwu_pkg::MWU_RESP: begin
        if (lnk.rsp_ready) begin
          s_d.rsp_valid = 1'b0;
          s_d.st = mwu_pkg::MWU_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : mwu_dev_end

//--- verilog/mwu_mst_end.sv
`timescale 1ns/1ps
`include "mwu_defines.svh"
module mwu_mst_end (
  input wire logic mclk,
  input wire logic rst_b,
  mwu_link.mst lnk,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq
);

  // ********************
  // State
  // ********************
  mwu_pkg::mwu_mst_st_t s_q;
  mwu_pkg::mwu_mst_st_t s_d;
  logic [2:0] ev;

  // ********************
  // Link outputs
  // ********************
  // Fixed id and length
  assign lnk.req_msg_id = `MWU_ID_REQ;
  assign lnk.req_len = `MWU_LEN_REQ;
  assign lnk.req_valid = s_q.busy;
  assign lnk.req_tid = s_q.tid;
  assign lnk.req_mode = s_q.mode;
  assign lnk.req_addr = s_q.addr;
  assign lnk.req_keep = s_q.keep;
  assign lnk.req_set = s_q.set;
  // Replies are always absorbed into registers, so no stall is needed
  assign lnk.rsp_ready = 1'b1;

  assign sw_rdata = s_q.rdata;
  assign irq = |(s_q.stat & s_q.mask);

  always_comb begin
    ev = '0;
    s_d = s_q;
    s_d.rdata = '0;
    if (s_q.busy && lnk.req_ready) begin
      s_d.busy = 1'b0;
      ev[`MWU_STAT_SENT] = 1'b1;
    end
    if (lnk.rsp_valid) begin
      s_d.rsp_id = lnk.rsp_msg_id;
      s_d.rsp_len = lnk.rsp_len;
      s_d.rsp_code = lnk.rsp_code;
      s_d.rsp_data = lnk.rsp_data;
      s_d.rsp_tid = lnk.rsp_tid;
      s_d.rsp_mode = lnk.rsp_mode;
      if (lnk.rsp_msg_id == `MWU_ID_ERR) begin
        ev[`MWU_STAT_ERR] = 1'b1;
      end else begin
        ev[`MWU_STAT_NORM] = 1'b1;
      end
    end
    if (sw_wr) begin
      unique case (sw_addr)
        `MWU_REG_CTRL: begin
          // Launch ignored while a request is pending
          if (sw_wdata[0] && !s_q.busy) begin
            s_d.busy = 1'b1;
          end
        end
        `MWU_REG_TID: s_d.tid = sw_wdata[15:0];
        `MWU_REG_MODE: s_d.mode = sw_wdata[7:0];
        `MWU_REG_ADDR: s_d.addr = sw_wdata;
        `MWU_REG_KEEP_LO: s_d.keep[31:0] = sw_wdata;
        `MWU_REG_KEEP_HI: s_d.keep[63:32] = sw_wdata;
        `MWU_REG_SET_LO: s_d.set[31:0] = sw_wdata;
        `MWU_REG_SET_HI: s_d.set[63:32] = sw_wdata;
        `MWU_REG_STAT: s_d.stat = s_q.stat & ~sw_wdata[2:0];
        `MWU_REG_MASK: s_d.mask = sw_wdata[2:0];
        default: ;
      endcase
    end
    // New events win over a clear in the same cycle
    s_d.stat = s_d.stat | ev;
    if (sw_rd) begin
      unique case (sw_addr)
        `MWU_REG_CTRL: s_d.rdata = {31'h0000_0000, s_q.busy};
        `MWU_REG_TID: s_d.rdata = {16'h0000, s_q.tid};
        `MWU_REG_MODE: s_d.rdata = {24'h00_0000, s_q.mode};
        `MWU_REG_ADDR: s_d.rdata = s_q.addr;
        `MWU_REG_KEEP_LO: s_d.rdata = s_q.keep[31:0];
        `MWU_REG_KEEP_HI: s_d.rdata = s_q.keep[63:32];
        `MWU_REG_SET_LO: s_d.rdata = s_q.set[31:0];
        `MWU_REG_SET_HI: s_d.rdata = s_q.set[63:32];
        `MWU_REG_RSP_INFO: s_d.rdata = {s_q.rsp_len, s_q.rsp_code, s_q.rsp_id};
        `MWU_REG_RSP_DATA: s_d.rdata = s_q.rsp_data;
        `MWU_REG_STAT: s_d.rdata = {29'h0000_0000, s_q.stat};
        `MWU_REG_MASK: s_d.rdata = {29'h0000_0000, s_q.mask};
        `MWU_REG_RSP_ECHO: s_d.rdata = {8'h00, s_q.rsp_mode, s_q.rsp_tid};
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.mode <= `MWU_RST_MODE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : mwu_mst_end

//--- tb/mwu_props.sv
`timescale 1ns/1ps
// ****
// Link checker
// ****
module mwu_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_msg_id,
  input wire logic [15:0] req_len,
  input wire logic [15:0] req_tid,
  input wire logic [7:0] req_mode,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_msg_id,
  input wire logic [15:0] rsp_len,
  input wire logic [15:0] rsp_tid,
  input wire logic [7:0] rsp_mode,
  input wire logic [7:0] rsp_code
);
  logic [15:0] tid_q;
  logic [7:0] mode_q;
  logic take;
  logic good;
  assign take = req_valid && req_ready;
  // Width 011 counts as bad here too
  assign good = !req_mode[6] && (req_mode[2:0] inside {3'h1, 3'h2, 3'h4});
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tid_q <= 16'h0000;
      mode_q <= 8'h00;
    end else if (take) begin
      tid_q <= req_tid;
      mode_q <= req_mode;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence err_at2;
    ##2 (rsp_valid && rsp_msg_id == 8'h93);
  endsequence
  sequence rd_at7;
    ##7 (rsp_valid && rsp_msg_id == 8'h13 && rsp_len == 16'h0007);
  endsequence
  sequence mode_err;
    ##2 (rsp_valid && rsp_msg_id == 8'h93 && rsp_code == 8'h04);
  endsequence
  req_frame_a: assert property (
    req_valid |-> req_msg_id == 8'h12 && req_len == 16'h0017) else $error("bad request frame");
  tid_echo_a: assert property (
    rsp_valid |-> rsp_tid == tid_q) else $error("tid not echoed");
  mode_echo_a: assert property (
    rsp_valid |-> rsp_mode == mode_q) else $error("mode not echoed");
  norm_len_a: assert property (
    rsp_valid && rsp_msg_id == 8'h13 |-> rsp_len == (mode_q[5] ? 16'h0004 : 16'h0007))
    else $error("normal reply length wrong");
  nord_code_a: assert property (
    rsp_valid && rsp_msg_id == 8'h13 && mode_q[5] |-> rsp_code == 8'h00)
    else $error("no-read reply code wrong");
  err_len_a: assert property (
    rsp_valid && rsp_msg_id == 8'h93 |-> rsp_len == 16'h0003) else $error("error length wrong");
  bad_mode_a: assert property (
    take && !good |-> mode_err) else $error("bad mode not refused");
  read_wins_a: assert property (
    take && good && !req_mode[5] |-> err_at2 or rd_at7) else $error("readback reply missing");
  supp_quiet_a: assert property (
    take && good && req_mode[7] && req_mode[5] |=> (!(rsp_valid && rsp_msg_id == 8'h13))[*6])
    else $error("suppressed reply sent");
endmodule : mwu_props

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "mwu_defines.svh"
// ****
// Bench
// ****
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic irq;
  logic [31:0] reg_addr;
  logic [7:0] reg_be;
  logic [63:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [63:0] reg_rdata = 64'h0000_0000_0000_0000;
  logic addr_bad = 1'b0;
  logic dev_fail = 1'b0;
  logic [63:0] mem = 64'h1111_2222_3333_4412;
  logic [63:0] bm;
  logic [31:0] g_info, g_data, g_echo, g_stat;
  logic g_irq;
  logic [15:0] tid_n = 16'h1234;
  logic [7:0] cur_m;
  int n_wr = 0;
  int n_rd = 0;
  int cyc = 0;
  int miscompares = 0;
  int n_compared = 0;
  mwu_link lnk ();
  mwu_mst_end mwu_mst_end_i (.mclk(mclk), .rst_b(rst_b), .lnk(lnk), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  mwu_dev_end mwu_dev_end_i (.mclk(mclk), .rst_b(rst_b), .lnk(lnk), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_addr_bad(addr_bad), .reg_fail(dev_fail));
  mwu_props mwu_props_i (.mclk(mclk), .rst_b(rst_b), .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_msg_id(lnk.req_msg_id), .req_len(lnk.req_len),
    .req_tid(lnk.req_tid), .req_mode(lnk.req_mode), .rsp_valid(lnk.rsp_valid),
    .rsp_msg_id(lnk.rsp_msg_id), .rsp_len(lnk.rsp_len), .rsp_tid(lnk.rsp_tid),
    .rsp_mode(lnk.rsp_mode), .rsp_code(lnk.rsp_code));
  // Second device on a bench-driven link: the master end always frames id 18, length 23
  mwu_link raw ();
  mwu_dev_end mwu_dev_end_i2 (.mclk(mclk), .rst_b(rst_b), .lnk(raw), .reg_addr(), .reg_be(),
    .reg_wdata(), .reg_wr(), .reg_rd(), .reg_rdata(64'h0000_0000_0000_0000),
    .reg_addr_bad(1'b0), .reg_fail(1'b0));
  always #2.5 mclk = ~mclk;
  always_comb for (int i = 0; i < 8; i++) bm[i*8 +: 8] = {8{reg_be[i]}};
  // Register model: one location, counts real strobes
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (reg_wr) mem <= (mem & ~bm) | (reg_wdata & bm);
    if (reg_wr) n_wr <= n_wr + 1;
    if (reg_rd) n_rd <= n_rd + 1;
    reg_rdata <= mem;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : rd
  // Fixed wait covers the longest reply of seven cycles
  task automatic txn(input logic [7:0] m, input logic [63:0] k, input logic [63:0] s);
    tid_n = tid_n + 16'h0111;
    cur_m = m;
    wr(`MWU_REG_TID, {16'h0000, tid_n});
    wr(`MWU_REG_MODE, {24'h00_0000, m});
    wr(`MWU_REG_ADDR, 32'hFFFF_FFF0);
    wr(`MWU_REG_KEEP_LO, k[31:0]);
    wr(`MWU_REG_KEEP_HI, k[63:32]);
    wr(`MWU_REG_SET_LO, s[31:0]);
    wr(`MWU_REG_SET_HI, s[63:32]);
    n_wr = 0;
    n_rd = 0;
    wr(`MWU_REG_CTRL, 32'h0000_0001);
    repeat (16) @(posedge mclk);
    rd(`MWU_REG_RSP_INFO, g_info);
    rd(`MWU_REG_RSP_DATA, g_data);
    rd(`MWU_REG_RSP_ECHO, g_echo);
    rd(`MWU_REG_STAT, g_stat);
    g_irq = irq;
    wr(`MWU_REG_STAT, 32'h0000_0007);
  endtask : txn
  task automatic rsp_ok(input logic [15:0] len, input logic [31:0] d, input int nrd);
    chk(g_info[31:16], len);
    chk(g_info[7:0], 8'h13);
    chk(g_echo[23:0], {cur_m, tid_n});
    chk(len == 16'h0007 ? g_data : g_info[15:8], d);
    chk(g_stat[2:0], 3'h3);
    chk(n_wr, 1);
    chk(n_rd, nrd);
    chk(reg_addr, 32'hFFFF_FFF0);
  endtask : rsp_ok
  task automatic t_read8();
    // Upper keep bits clear, so an unmasked merge would corrupt the upper bytes
    txn(8'h01, 64'h0000_0000_0000_00F2, 64'hFFFF_FFFF_FFFF_FF25);
    chk(mem, 64'h1111_2222_3333_4417);
    rsp_ok(16'h0007, 32'h0000_0017, 2);
    $display("test read8 done");
  endtask : t_read8
  task automatic t_noread16();
    txn(8'h22, 64'hFFFF_FFFF_FFFF_00FF, 64'h0000_0000_0000_AB00);
    chk(mem, 64'h1111_2222_3333_AB17);
    rsp_ok(16'h0004, 32'h0000_0000, 1);
    $display("test noread16 done");
  endtask : t_noread16
  task automatic t_supp16();
    txn(8'hA2, 64'h0000_0000_0000_0000, 64'h0000_0000_0000_5A5A);
    chk(mem, 64'h1111_2222_3333_5A5A);
    chk(g_stat[2:0], 3'h1);
    chk(n_wr, 1);
    $display("test supp16 done");
  endtask : t_supp16
  task automatic t_supprd64();
    txn(8'h84, 64'hFFFF_FFFF_0000_0000, 64'h0000_0000_CAFE_F00D);
    chk(mem, 64'h1111_2222_CAFE_F00D);
    rsp_ok(16'h0007, 32'hCAFE_F00D, 2);
    $display("test supprd64 done");
  endtask : t_supprd64
  task automatic t_errors();
    logic [7:0] md [10] = '{8'h41, 8'h00, 8'h05, 8'h06, 8'h07, 8'h03, 8'hE1, 8'hA1, 8'h01, 8'h42};
    logic [9:0] bad = 10'h086;
    logic [9:0] fl = 10'h381;
    logic [7:0] rc [10] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h0A, 8'hFF, 8'h04};
    logic [63:0] old;
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      addr_bad <= bad[i];
      dev_fail <= fl[i];
      old = mem;
      txn(md[i], 64'h0000_0000_0000_0000, 64'h0000_0000_0000_00C3);
      chk(mem, old);
      chk(n_wr, 0);
      chk(g_info, {16'h0003, rc[i], 8'h93});
      chk(g_echo[15:0], tid_n);
      chk(g_stat[2:0], 3'h5);
      chk(g_irq, 1'b0);
    end
    addr_bad <= 1'b0;
    dev_fail <= 1'b0;
    $display("test errors done");
  endtask : t_errors
  task automatic t_irq();
    wr(`MWU_REG_MASK, 32'h0000_0004);
    txn(8'h21, 64'h0000_0000_0000_00FF, 64'h0000_0000_0000_0000);
    chk(g_irq, 1'b0);
    txn(8'h00, 64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000);
    chk(g_irq, 1'b1);
    @(posedge mclk);
    #1 chk(irq, 1'b0);
    $display("test irq done");
  endtask : t_irq
  task automatic t_frame();
    logic [7:0] id [3] = '{8'h11, 8'h12, 8'h00};
    logic [15:0] ln [3] = '{16'h0017, 16'h0016, 16'h0000};
    logic [7:0] rc [3] = '{8'h01, 8'h02, 8'h01};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      raw.req_valid <= 1'b1;
      raw.req_msg_id <= id[i];
      raw.req_len <= ln[i];
      do @(posedge mclk); while (!raw.req_ready);
      raw.req_valid <= 1'b0;
      @(posedge mclk);
      #1 chk(raw.rsp_valid, 1'b1);
      chk({raw.rsp_len, raw.rsp_code, raw.rsp_msg_id}, {16'h0003, rc[i], 8'h93});
      chk(raw.rsp_tid, 16'h0ABC);
    end
    $display("test frame done");
  endtask : t_frame
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    raw.req_valid <= 1'b0;
    raw.rsp_ready <= 1'b1;
    raw.req_msg_id <= 8'h12;
    raw.req_len <= 16'h0017;
    raw.req_tid <= 16'h0ABC;
    raw.req_mode <= 8'h01;
    raw.req_addr <= 32'h0000_0000;
    raw.req_keep <= 64'h0000_0000_0000_0000;
    raw.req_set <= 64'h0000_0000_0000_0000;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_read8();
    t_noread16();
    t_supp16();
    t_supprd64();
    t_errors();
    t_irq();
    t_frame();
    final_report();
  end
endmodule : testbench
